// [strap_detector.v]
// Detects the serial port strap: pin held low after power-on release.
// Assumes the pin is asynchronous to clock and arst_n is power-on reset.
`include "system_reset_status_options_consts.vh"

module strap_detector (
  input wire clock,
  input wire arst_n,
  input wire strap_pin,
  output wire strap_hit
);
  localparam integer hold_int = `SPI_STRAP_MIN_CYCLES;
  localparam [`STRAP_CNT_WIDTH-1:0] hold_cycles =
    hold_int[`STRAP_CNT_WIDTH-1:0];
  reg sync1_r;
  reg sync2_r;
  reg [1:0] fill_r;
  reg window_r;
  reg hit_r;
  reg [`STRAP_CNT_WIDTH-1:0] count_r;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      fill_r <= 2'b00;
    end else begin
      sync1_r <= strap_pin;
      sync2_r <= sync1_r;
      fill_r <= {fill_r[0], 1'b1};
    end
  end

  // The window opens at power-on release and closes on the first high level,
  // so a low pin seen much later never turns the port on.
  // The first two edges still show the reset level of the synchroniser,
  // not the pin, so the window waits until the pin has passed through.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      window_r <= 1'b1;
      hit_r <= 1'b0;
      count_r <= {`STRAP_CNT_WIDTH{1'b0}};
    end else if (window_r && fill_r[1]) begin
      if (sync2_r) begin
        window_r <= 1'b0;
      end else if (count_r == hold_cycles) begin
        hit_r <= 1'b1; // see RULE16
        window_r <= 1'b0;
      end else begin
        count_r <= count_r + 1'b1;
      end
    end
  end

  assign strap_hit = hit_r;
endmodule // strap_detector

// [system_reset_status_options.v]
// Reset-cause status, debug forced reset and option register bank.
// Assumes arst_n is the power-on reset, reset requests are one-cycle pulses
// from logic on clock, and a classic Wishbone master with 32-bit data.
//
// Behaviour
// RULE1: power-on reset sets power-on flag.
// RULE2: power wake-up reset sets status bit 2.
// RULE3: flags kept across all non-power-on resets.
// RULE4: low-voltage or power-on reset sets bit 1.
// RULE5: soft flag reads 1 once, then 0.
// RULE6: debug-mode write of 1 forces system reset.
// RULE7: forced reset sets no flag by itself.
// RULE8: watchdog and stop bits accept first write only.
// RULE9: radio, serial, debug pin bits always writable.
// RULE10: stop exit is not a power-on reset.
// RULE11: bit 7 enables watchdog, resets to 1.
// RULE12: bit 6 selects watchdog clock, resets to 0.
// RULE13: disabled stop instruction causes illegal opcode reset.
// RULE14: radio enable cleared only by power-on reset.
// RULE15: bit 2 enables serial port, resets 0.
// RULE16: low strap at power-on release enables serial port.
// RULE17: bit 1 selects debug pin function, resets 1.
// RULE18: status writes change no flag.
//
// Design decision made here: the Wishbone register port.
`include "system_reset_status_options_consts.vh"

module system_reset_status_options (
  input wire clock,
  input wire arst_n,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire background_debug_mode,
  input wire pwu_reset_req,
  input wire lvr_reset_req,
  input wire soft_reset_req,
  input wire other_reset_req,
  input wire stop_instr_exec,
  input wire port_a_bit0_strap,
  output wire system_reset_out,
  output wire stop_mode_enter,
  output wire watchdog_enable,
  output wire watchdog_clock_select,
  output wire stop_instruction_enable,
  output wire radio_tx_enable,
  output wire serial_port_enable,
  output wire debug_pin_enable,
  output wire irq
);

  // Bus registers.
  reg ack_r;
  reg [31:0] dat_r;

  // Reset-cause flags.
  reg por_flag_r;
  reg ilop_flag_r;
  reg pwu_flag_r;
  reg lvr_flag_r;
  reg soft_flag_r;

  // Option bits.
  reg wd_enable_r;
  reg wd_clk_sel_r;
  reg stop_enable_r;
  reg once_done_r;
  reg radio_en_r;
  reg spi_bit_r;
  reg debug_pin_r;

  // Outputs driven from flip-flops.
  reg system_reset_r;
  reg stop_enter_r;
  reg spi_enable_r;
  reg irq_r;

  // Event interrupt registers.
  reg [`EVT_WIDTH-1:0] evt_status_r;
  reg [`EVT_WIDTH-1:0] evt_enable_r;

  // Combinational terms.
  reg [31:0] rd_data;
  reg hit_status;
  reg hit_control;
  reg hit_option;
  reg hit_evt_status;
  reg hit_evt_enable;
  reg hit_evt_clear;

  wire [13:0] index;
  wire access;
  wire wr_low;
  wire rd;
  wire debug_forced;
  wire illegal_stop;
  wire flagged_reset;
  wire system_reset_now;
  wire strap_hit;
  wire [`EVT_WIDTH-1:0] events;
  wire [`EVT_WIDTH-1:0] evt_clear;
  wire [`EVT_WIDTH-1:0] evt_status_nxt;

  strap_detector u_strap (
    .clock(clock),
    .arst_n(arst_n),
    .strap_pin(port_a_bit0_strap),
    .strap_hit(strap_hit)
  );

  // A request is taken in the cycle before ack; the ack then drops at once,
  // which gives the master exactly one ack per request.
  assign index = wb_adr_i[15:2];
  assign access = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_low = access & wb_we_i & wb_sel_i[0];
  assign rd = access & ~wb_we_i;

  always @* begin
    hit_status = 1'b0;
    hit_control = 1'b0;
    hit_option = 1'b0;
    hit_evt_status = 1'b0;
    hit_evt_enable = 1'b0;
    hit_evt_clear = 1'b0;
    if (index == `IDX_RESET_CAUSE_STATUS) begin
      hit_status = 1'b1;
    end else if (index == `IDX_SYSTEM_CONTROL) begin
      hit_control = 1'b1;
    end else if (index == `IDX_SYSTEM_OPTION_ONE) begin
      hit_option = 1'b1;
    end else if (index == `IDX_EVENT_STATUS) begin
      hit_evt_status = 1'b1;
    end else if (index == `IDX_EVENT_ENABLE) begin
      hit_evt_enable = 1'b1;
    end else if (index == `IDX_EVENT_CLEAR) begin
      hit_evt_clear = 1'b1;
    end
  end

  // Writing 0, or writing outside debug mode, has no effect.
  assign debug_forced = wr_low & hit_control & background_debug_mode &
    wb_dat_i[`CTRL_DEBUG_FORCED_RESET_BIT]; // see RULE6

  assign illegal_stop = stop_instr_exec & ~stop_enable_r; // see RULE13

  assign flagged_reset = pwu_reset_req | lvr_reset_req | soft_reset_req |
    other_reset_req | illegal_stop;

  assign system_reset_now = flagged_reset | debug_forced; // see RULE6

  // Read data.
  always @* begin
    rd_data = 32'h0000_0000;
    if (hit_status) begin
      rd_data[`RCS_POWER_ON_BIT] = por_flag_r;
      rd_data[`RCS_ILLEGAL_OP_BIT] = ilop_flag_r;
      rd_data[`RCS_PWU_BIT] = pwu_flag_r;
      rd_data[`RCS_LVR_BIT] = lvr_flag_r;
      rd_data[`RCS_SOFT_BIT] = soft_flag_r;
    end else if (hit_option) begin
      rd_data[`OPT_WATCHDOG_ENABLE_BIT] = wd_enable_r;
      rd_data[`OPT_WATCHDOG_CLK_SEL_BIT] = wd_clk_sel_r;
      rd_data[`OPT_STOP_ENABLE_BIT] = stop_enable_r;
      rd_data[`OPT_RADIO_TX_ENABLE_BIT] = radio_en_r;
      rd_data[`OPT_SERIAL_PORT_ENABLE_BIT] = spi_bit_r;
      rd_data[`OPT_DEBUG_PIN_ENABLE_BIT] = debug_pin_r;
      rd_data[`OPT_FIXED_ONE_BIT] = 1'b1;
    end else if (hit_evt_status) begin
      rd_data[`EVT_WIDTH-1:0] = evt_status_r;
    end else if (hit_evt_enable) begin
      rd_data[`EVT_WIDTH-1:0] = evt_enable_r;
    end
  end

  // Unmapped addresses are acknowledged and read as zero.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= access;
      if (rd) begin
        dat_r <= rd_data;
      end
    end
  end

  // Only the power-on reset reaches these flags asynchronously; every other
  // reset source, including stop exit, sets at most its own flag and clears none. // see RULE10
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      por_flag_r <= 1'b1; // see RULE1
      ilop_flag_r <= 1'b0;
      pwu_flag_r <= 1'b0;
      lvr_flag_r <= 1'b1; // see RULE4
      soft_flag_r <= 1'b0; // see RULE5
    end else begin
      // Status writes are decoded but touch no flag. // see RULE18
      if (illegal_stop) begin
        ilop_flag_r <= 1'b1; // see RULE13
      end
      if (pwu_reset_req) begin
        pwu_flag_r <= 1'b1; // see RULE2
      end
      if (lvr_reset_req) begin
        lvr_flag_r <= 1'b1; // see RULE4
      end
      // A new soft reset beats the clear from a read in the same cycle.
      if (soft_reset_req) begin
        soft_flag_r <= 1'b1; // see RULE5
      end else if (rd & hit_status) begin
        soft_flag_r <= 1'b0; // see RULE5
      end
      // The forced reset sets none of these flags. // see RULE7
      // Flags are not cleared on other resets. // see RULE3
    end
  end

  // Option register; a system reset restores all bits except radio enable.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wd_enable_r <= `OPT_WATCHDOG_ENABLE_RST; // see RULE11
      wd_clk_sel_r <= `OPT_WATCHDOG_CLK_SEL_RST; // see RULE12
      stop_enable_r <= `OPT_STOP_ENABLE_RST; // see RULE13
      once_done_r <= 1'b0;
      radio_en_r <= 1'b0; // see RULE14
      spi_bit_r <= `OPT_SERIAL_PORT_ENABLE_RST; // see RULE15
      debug_pin_r <= `OPT_DEBUG_PIN_ENABLE_RST; // see RULE17
    end else if (system_reset_now) begin
      wd_enable_r <= `OPT_WATCHDOG_ENABLE_RST; // see RULE11
      wd_clk_sel_r <= `OPT_WATCHDOG_CLK_SEL_RST; // see RULE12
      stop_enable_r <= `OPT_STOP_ENABLE_RST; // see RULE13
      once_done_r <= 1'b0; // see RULE8
      spi_bit_r <= `OPT_SERIAL_PORT_ENABLE_RST; // see RULE15
      debug_pin_r <= `OPT_DEBUG_PIN_ENABLE_RST; // see RULE17
      // Radio enable survives. // see RULE14
    end else if (wr_low & hit_option) begin
      if (!once_done_r) begin
        wd_enable_r <= wb_dat_i[`OPT_WATCHDOG_ENABLE_BIT]; // see RULE8
        wd_clk_sel_r <= wb_dat_i[`OPT_WATCHDOG_CLK_SEL_BIT]; // see RULE8
        stop_enable_r <= wb_dat_i[`OPT_STOP_ENABLE_BIT]; // see RULE8
        once_done_r <= 1'b1; // see RULE8
      end
      radio_en_r <= wb_dat_i[`OPT_RADIO_TX_ENABLE_BIT]; // see RULE9
      spi_bit_r <= wb_dat_i[`OPT_SERIAL_PORT_ENABLE_BIT]; // see RULE9
      debug_pin_r <= wb_dat_i[`OPT_DEBUG_PIN_ENABLE_BIT]; // see RULE9
    end
  end

  // Event interrupts; a new event wins over a clear in the same cycle.
  assign events[`EVT_PWU_BIT] = pwu_reset_req;
  assign events[`EVT_LVR_BIT] = lvr_reset_req;
  assign events[`EVT_SOFT_BIT] = soft_reset_req;
  assign events[`EVT_DEBUG_FORCED_BIT] = debug_forced;
  assign events[`EVT_ILLEGAL_STOP_BIT] = illegal_stop;

  assign evt_clear = (wr_low & hit_evt_clear) ?
    wb_dat_i[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}};
  assign evt_status_nxt = (evt_status_r & ~evt_clear) | events;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      evt_status_r <= {`EVT_WIDTH{1'b0}};
      evt_enable_r <= {`EVT_WIDTH{1'b0}};
      irq_r <= 1'b0;
    end else begin
      evt_status_r <= evt_status_nxt;
      if (wr_low & hit_evt_enable) begin
        evt_enable_r <= wb_dat_i[`EVT_WIDTH-1:0];
      end
      irq_r <= |(evt_status_nxt & evt_enable_r);
    end
  end

  // Output stage. The serial port follows the bit or the strap, one cycle
  // late, which is harmless since port muxing is a static choice.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      system_reset_r <= 1'b0;
      stop_enter_r <= 1'b0;
      spi_enable_r <= 1'b0;
    end else begin
      system_reset_r <= system_reset_now; // see RULE6
      stop_enter_r <= stop_instr_exec & stop_enable_r; // see RULE13
      spi_enable_r <= spi_bit_r | strap_hit; // see RULE15 see RULE16
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign system_reset_out = system_reset_r;
  assign stop_mode_enter = stop_enter_r;
  assign watchdog_enable = wd_enable_r; // see RULE11
  assign watchdog_clock_select = wd_clk_sel_r; // see RULE12
  assign stop_instruction_enable = stop_enable_r;
  assign radio_tx_enable = radio_en_r; // see RULE14
  assign serial_port_enable = spi_enable_r;
  assign debug_pin_enable = debug_pin_r; // see RULE17
  assign irq = irq_r;

endmodule // system_reset_status_options

// [system_reset_status_options_consts.vh]
// Constants shared by the reset-status and option register block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SYSTEM_RESET_STATUS_OPTIONS_CONSTS_VH
`define SYSTEM_RESET_STATUS_OPTIONS_CONSTS_VH

// Register indices; the byte address on the bus is four times the index.
`define IDX_RESET_CAUSE_STATUS 14'h1800
`define IDX_SYSTEM_CONTROL 14'h1801
`define IDX_SYSTEM_OPTION_ONE 14'h1802
`define IDX_EVENT_STATUS 14'h1810
`define IDX_EVENT_ENABLE 14'h1811
`define IDX_EVENT_CLEAR 14'h1812

// Reset-cause status fields.
`define RCS_POWER_ON_BIT 7
`define RCS_ILLEGAL_OP_BIT 4
`define RCS_PWU_BIT 2
`define RCS_LVR_BIT 1
`define RCS_SOFT_BIT 0
`define RCS_POR_VALUE 8'h82

// System control fields.
`define CTRL_DEBUG_FORCED_RESET_BIT 0

// Option register fields and reset values.
`define OPT_WATCHDOG_ENABLE_BIT 7
`define OPT_WATCHDOG_CLK_SEL_BIT 6
`define OPT_STOP_ENABLE_BIT 5
`define OPT_RADIO_TX_ENABLE_BIT 4
`define OPT_SERIAL_PORT_ENABLE_BIT 2
`define OPT_DEBUG_PIN_ENABLE_BIT 1
`define OPT_FIXED_ONE_BIT 0
`define OPT_POR_VALUE 8'h83
`define OPT_WATCHDOG_ENABLE_RST 1'b1
`define OPT_WATCHDOG_CLK_SEL_RST 1'b0
`define OPT_STOP_ENABLE_RST 1'b0
`define OPT_SERIAL_PORT_ENABLE_RST 1'b0
`define OPT_DEBUG_PIN_ENABLE_RST 1'b1

// Event bits shared by event status, enable and clear.
`define EVT_PWU_BIT 0
`define EVT_LVR_BIT 1
`define EVT_SOFT_BIT 2
`define EVT_DEBUG_FORCED_BIT 3
`define EVT_ILLEGAL_STOP_BIT 4
`define EVT_WIDTH 5

// Timing.
`define CLOCK_PERIOD_NS 10
`define SPI_STRAP_MIN_NS 1000
`define SPI_STRAP_MIN_CYCLES \
  ((`SPI_STRAP_MIN_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define STRAP_CNT_WIDTH 16

`endif

// [system_reset_status_options_props.sv]
// Concurrent checks for the reset-status and option register bank.
// Assumes a bind to the top module; it sees only that module's ports.
module system_reset_status_options_props (
  input logic clock,
  input logic arst_n,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [15:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic wb_ack_o,
  input logic background_debug_mode,
  input logic pwu_reset_req,
  input logic lvr_reset_req,
  input logic soft_reset_req,
  input logic other_reset_req,
  input logic stop_instr_exec,
  input logic system_reset_out,
  input logic stop_mode_enter,
  input logic watchdog_enable,
  input logic watchdog_clock_select,
  input logic stop_instruction_enable,
  input logic debug_pin_enable
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire any_req = pwu_reset_req | lvr_reset_req | soft_reset_req |
    other_reset_req;
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  // A control write is only seen on the taking edge, not while ack shows.
  wire ctl_wr = take & wb_we_i & wb_sel_i[0] &
    (wb_adr_i[15:2] == 14'h1801);
  wire force_rst = wb_dat_i[0] & background_debug_mode;
  a_req_resets: assert property (any_req |=> system_reset_out)
    else $error("reset request gave no system reset");
  a_debug_force: assert property (
    ctl_wr & force_rst |=> system_reset_out)
    else $error("debug forced reset missing");
  a_debug_idle: assert property (
    ctl_wr & !force_rst & !any_req & !stop_instr_exec |=> !system_reset_out)
    else $error("control write reset without cause");
  a_stop_illegal: assert property (
    stop_instr_exec & !stop_instruction_enable |=>
    system_reset_out & !stop_mode_enter)
    else $error("disabled stop did not reset");
  a_stop_legal: assert property (
    stop_instr_exec & stop_instruction_enable & !any_req |=> stop_mode_enter)
    else $error("enabled stop did not enter stop");
  // The reset pulse shows at the same edge as the option bits are restored,
  // and a write in the reset cycle is lost, so both agree at that edge.
  a_opt_defaults: assert property (
    system_reset_out |-> watchdog_enable & !watchdog_clock_select &
    !stop_instruction_enable & debug_pin_enable)
    else $error("option pins not at reset values");
  a_ack_once: assert property (take |=> wb_ack_o)
    else $error("bus request not acknowledged");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule // system_reset_status_options_props

// [system_reset_status_options_tb_top.sv]
// Self-checking bench for the reset-status and option register bank.
// Assumes the design files and the checker file are compiled first.
module system_reset_status_options_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, arst_n = 0, cyc = 0, stb = 0, we = 0, bdm = 0;
  logic strap = 1;
  logic [15:0] adr = 0;
  logic [31:0] wdat = 0, rdat;
  logic [4:0] rq = 0;
  wire [31:0] dat_o;
  wire ack, sro, sme, wde, wdc, sie, rte, spe, dpe, irq;
  int err_total = 0, checks_done = 0;
  int st, opt, lock, evs, eve;
  int flag[5] = '{8'h04, 8'h02, 8'h01, 8'h00, 8'h10};
  int evb[5] = '{8'h01, 8'h02, 8'h04, 8'h00, 8'h10};
  initial forever #5 clock = ~clock;
  system_reset_status_options i_dut (.clock(clock), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .background_debug_mode(bdm), .pwu_reset_req(rq[0]),
    .lvr_reset_req(rq[1]), .soft_reset_req(rq[2]),
    .other_reset_req(rq[3]), .stop_instr_exec(rq[4]),
    .port_a_bit0_strap(strap), .system_reset_out(sro),
    .stop_mode_enter(sme), .watchdog_enable(wde),
    .watchdog_clock_select(wdc), .stop_instruction_enable(sie),
    .radio_tx_enable(rte), .serial_port_enable(spe),
    .debug_pin_enable(dpe), .irq(irq));
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task por;
    st = 8'h82;
    opt = 8'h83;
    lock = 0;
    evs = 0;
    eve = 0;
  endtask
  // Radio enable survives every system reset; only power-on clears it.
  task sysrst;
    opt = (opt & 8'h10) | 8'h83;
    lock = 0;
  endtask
  task automatic bus(logic w, logic [13:0] idx, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {idx, 2'h0};
    wdat <= d;
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'h1 && n < 50);
    if (n >= 50) err_total++;
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic rd(logic [13:0] idx);
    int e;
    e = 0;
    case (idx)
      14'h1800: e = st;
      14'h1802: e = opt;
      14'h1810: e = evs;
      14'h1811: e = eve;
    endcase
    bus(1'h0, idx, 32'h0);
    chk($sformatf("reg %h", idx), rdat, e);
    if (idx == 14'h1800) st &= 8'hfe;
  endtask
  task automatic wr(logic [13:0] idx, logic [31:0] d);
    bus(1'h1, idx, d);
    case (idx)
      14'h1801: if (d[0] && bdm) begin
        evs |= 8'h08;
        sysrst();
      end
      14'h1802: begin
        if (!lock) opt = (opt & 8'h1f) | (d & 8'he0);
        opt = (opt & 8'he9) | (d & 8'h16);
        lock = 1;
      end
      14'h1811: eve = d & 8'h1f;
      14'h1812: evs &= ~d;
    endcase
  endtask
  task automatic pulse(int i);
    @(posedge clock);
    rq[i] <= 1'h1;
    @(posedge clock);
    rq[i] <= 1'h0;
    repeat (2) @(posedge clock);
    if (i != 4 || !opt[5]) begin
      st |= flag[i];
      evs |= evb[i];
      sysrst();
    end
  endtask
  // Pins are registered with up to one cycle of lag, so wait an edge.
  task outs;
    @(posedge clock);
    chk("option pins", {wde, wdc, sie, rte, 1'h0, spe, dpe, 1'h1}, opt);
    chk("irq", irq, (evs & eve) != 0);
  endtask
  task final_report;
    if (err_total == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    final_report();
  end
  initial begin
    logic [31:0] d;
    void'($urandom(88492));
    repeat (8) @(posedge clock);
    arst_n <= 1'h1;
    por();
    rd(14'h1800);
    rd(14'h1802);
    rd(14'h1801);
    rd(14'h1804);
    outs();
    wr(14'h1811, 32'h1f);
    rd(14'h1811);
    pulse(2);
    rd(14'h1800);
    rd(14'h1800);
    outs();
    wr(14'h1812, 32'h1f);
    outs();
    pulse(0);
    pulse(1);
    rd(14'h1800);
    wr(14'h1800, 32'hff);
    rd(14'h1800);
    repeat (4) begin
      d = $urandom;
      wr(14'h1802, d);
      rd(14'h1802);
      outs();
    end
    pulse(3);
    rd(14'h1800);
    rd(14'h1802);
    outs();
    wr(14'h1802, 32'h0);
    pulse(4);
    rd(14'h1800);
    wr(14'h1802, 32'h20);
    pulse(4);
    rd(14'h1800);
    outs();
    wr(14'h1801, 32'h1);
    rd(14'h1802);
    bdm <= 1'h1;
    wr(14'h1801, 32'h0);
    rd(14'h1802);
    wr(14'h1801, 32'h1);
    rd(14'h1802);
    rd(14'h1800);
    rd(14'h1810);
    @(posedge clock);
    arst_n <= 1'h0;
    strap <= 1'h0;
    repeat (8) @(posedge clock);
    arst_n <= 1'h1;
    por();
    repeat (150) @(posedge clock);
    chk("serial strap", spe, 1'h1);
    rd(14'h1800);
    final_report();
  end
endmodule // system_reset_status_options_tb_top
bind system_reset_status_options system_reset_status_options_props
  i_props (.*);
